// *** csa_serial_ctrl.sv ***
// Three-wire clocked serial interface with buffer RAM automatic transfer
// ============================================================================
// Behaviour
// - Eight-bit mode register, byte writable, zero after reset.
// - Unit disabled: data out low, clock high, internal serial logic held reset.
// - Disable clears address counter, trigger, shift register and busy flag.
// - Mode bit 6 picks single byte or automatic buffer RAM transfer.
// - Automatic single mode stops when counter reaches the end pointer.
// - Repeat mode resumes from buffer start once software zeroes the counter.
// - Mode bit 4 picks slave on external clock or master on internal clock.
// - Transmit disabled keeps serial data out low.
// - Receive disabled ignores incoming serial data.
// - Mode bit 1 picks MSB first when clear, LSB first when set.
// - Unit disabled blocks processor access to the buffer RAM.
// - Buffer RAM contents are undefined after disable and re-enable.
// ============================================================================
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module csa_serial_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // Serial link
  input  wire logic        serial_data_in_i,
  output var  logic        serial_data_out_o,
  input  wire logic        serial_clock_line_i,
  output var  logic        serial_clock_line_o,
  output var  logic        serial_clock_line_oe_o
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [7:0]                   serial_mode_control;
  logic [csa_pkg::BUF_AW-1:0]   transfer_end_pointer;
  logic [csa_pkg::BUF_AW:0]     transfer_address_counter;
  logic                         serial_trigger;
  logic [7:0]                   serial_shift_register;
  logic                         transfer_in_progress_flag;
  logic [7:0]                   buf_ram [csa_pkg::BUF_DEPTH];
  csa_pkg::csa_state_type       state;
  logic [3:0]                   bit_cnt;
  logic [4:0]                   half_cnt;
  logic                         out_bit;
  logic                         sck_prev;
  logic [1:0]                   pin_level;
  logic                         unit_en;
  logic                         auto_en;
  logic                         repeat_en;
  logic                         master;
  logic                         tx_en;
  logic                         rx_en;
  logic                         lsb_first;
  logic                         bus_req;
  logic                         bus_wr;
  logic                         bus_rd;
  logic                         buf_hit;
  logic [csa_pkg::BUF_AW-1:0]   buf_idx;
  logic                         auto_pending;
  logic                         single_start;
  logic                         auto_start;
  logic                         rise;
  logic                         fall;
  logic                         m_tick;
  logic                         last_rise;
  logic                         in_bit;
  logic                         fifo_in_ready;
  logic                         fifo_out_valid;
  logic [7:0]                   fifo_out_data;
  logic                         fifo_push;
  logic                         fifo_pop;
  logic [31:0]                  next_rd_data;

  // Head bit of the shift register for the chosen order
  function automatic logic head_bit(input logic [7:0] sr, input logic lsb);
    return lsb ? sr[0] : sr[7];
  endfunction

  // Register select for an address
  function automatic logic addr_is(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction

  // Mode field decode
  assign unit_en   = serial_mode_control[csa_pkg::BIT_UNIT_EN];
  assign auto_en   = serial_mode_control[csa_pkg::BIT_AUTO_EN];
  assign repeat_en = serial_mode_control[csa_pkg::BIT_REPEAT];
  assign master    = serial_mode_control[csa_pkg::BIT_ROLE];
  assign tx_en     = serial_mode_control[csa_pkg::BIT_TX_EN];
  assign rx_en     = serial_mode_control[csa_pkg::BIT_RX_EN];
  assign lsb_first = serial_mode_control[csa_pkg::BIT_ORDER];

  // ==========================================================================
  // Wishbone access decode
  // ==========================================================================
  // Requests are taken on the edge that raises ack
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
  assign bus_rd  = bus_req && !wb_we_i;
  assign buf_hit = (wb_adr_i >= csa_pkg::ADDR_BUF_LO) && (wb_adr_i <= csa_pkg::ADDR_BUF_HI)
                   && (wb_adr_i[1:0] == 2'h0);
  assign buf_idx = wb_adr_i[csa_pkg::BUF_AW+1:2];

  // Acknowledge one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Read data multiplexer; unmapped addresses read zero
  always_comb begin
    next_rd_data = 32'h0000_0000;
    if (addr_is(wb_adr_i, csa_pkg::ADDR_MODE)) begin
      next_rd_data[7:0] = serial_mode_control;
    end else if (addr_is(wb_adr_i, csa_pkg::ADDR_END_PTR)) begin
      next_rd_data[csa_pkg::BUF_AW-1:0] = transfer_end_pointer;
    end else if (addr_is(wb_adr_i, csa_pkg::ADDR_ADR_CNT)) begin
      next_rd_data[csa_pkg::BUF_AW:0] = transfer_address_counter;
    end else if (addr_is(wb_adr_i, csa_pkg::ADDR_TRIGGER)) begin
      next_rd_data[csa_pkg::BIT_TRIG] = serial_trigger;
    end else if (addr_is(wb_adr_i, csa_pkg::ADDR_STATUS)) begin
      next_rd_data[csa_pkg::BIT_ST_BUSY]   = transfer_in_progress_flag;
      next_rd_data[csa_pkg::BIT_ST_RXVAL]  = fifo_out_valid;
      next_rd_data[csa_pkg::BIT_ST_RXFULL] = !fifo_in_ready;
      next_rd_data[csa_pkg::BIT_ST_ADONE]  = auto_en && !auto_pending;
    end else if (addr_is(wb_adr_i, csa_pkg::ADDR_SHIFT)) begin
      next_rd_data[7:0] = serial_shift_register;
    end else if (addr_is(wb_adr_i, csa_pkg::ADDR_RX_DATA)) begin
      next_rd_data[7:0]                   = fifo_out_data;
      next_rd_data[csa_pkg::BIT_RX_VALID] = fifo_out_valid;
    end else if (buf_hit && unit_en) begin
      next_rd_data[7:0] = buf_ram[buf_idx];
    end
  end

  // Read data register presented with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_rd) begin
      wb_dat_o <= next_rd_data;
    end
  end

  // ==========================================================================
  // Mode register
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_mode_control <= csa_pkg::MODE_RESET;
    end else if (bus_wr && addr_is(wb_adr_i, csa_pkg::ADDR_MODE)) begin
      serial_mode_control <= wb_dat_i[7:0] & csa_pkg::MODE_WR_MASK;
    end
  end

  // End pointer is not cleared by disable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transfer_end_pointer <= '0;
    end else if (bus_wr && addr_is(wb_adr_i, csa_pkg::ADDR_END_PTR)) begin
      transfer_end_pointer <= wb_dat_i[csa_pkg::BUF_AW-1:0];
    end
  end

  // ==========================================================================
  // Serial pin sampling and edge detection
  // ==========================================================================
  csa_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({serial_clock_line_i, serial_data_in_i}),
    .init_i  (2'h2), // Clock idles high, data low
    .level_o (pin_level)
  );

  // Previous external clock level for edge finding
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_prev <= 1'b1;
    end else begin
      sck_prev <= pin_level[1];
    end
  end

  // Master half period timer
  always_ff @(posedge clk_i) begin
    if (rst_i || !unit_en || state != csa_pkg::ST_SHIFT) begin
      half_cnt <= '0;
    end else if (m_tick) begin
      half_cnt <= '0;
    end else begin
      half_cnt <= half_cnt + 1'b1;
    end
  end

  assign m_tick    = (half_cnt == 5'(csa_pkg::SCK_HALF_CYC - 1));
  // Slave uses the peer clock, master its own divider
  assign rise      = master ? (m_tick && !serial_clock_line_o && bit_cnt != 4'h8)
                            : (pin_level[1] && !sck_prev);
  assign fall      = master ? (m_tick && serial_clock_line_o && bit_cnt != 4'h8)
                            : (!pin_level[1] && sck_prev);
  assign last_rise = master ? (m_tick && bit_cnt == 4'h8) : (bit_cnt == 4'h8);
  assign in_bit    = rx_en ? pin_level[0] : 1'b0;

  // ==========================================================================
  // Transfer start conditions
  // ==========================================================================
  assign auto_pending = transfer_address_counter <= {1'b0, transfer_end_pointer};
  assign auto_start   = auto_en && serial_trigger && auto_pending;
  assign single_start = !auto_en && bus_wr && addr_is(wb_adr_i, csa_pkg::ADDR_SHIFT)
                        && (tx_en || rx_en) && (!rx_en || fifo_in_ready);

  // ==========================================================================
  // Transfer engine
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i || !unit_en) begin
      state   <= csa_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
    end else begin
      case (state)
        csa_pkg::ST_IDLE: begin
          bit_cnt <= 4'h0;
          if (single_start || auto_start) begin
            state <= csa_pkg::ST_LOAD;
          end
        end
        csa_pkg::ST_LOAD: begin
          state <= csa_pkg::ST_SHIFT;
        end
        csa_pkg::ST_SHIFT: begin
          if (last_rise) begin
            state <= csa_pkg::ST_STORE;
          end else if (rise) begin
            bit_cnt <= bit_cnt + 1'b1;
          end
        end
        csa_pkg::ST_STORE: begin
          state <= csa_pkg::ST_IDLE;
        end
        default: begin
          state <= csa_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Busy flag covers load, shift and store
  always_ff @(posedge clk_i) begin
    if (rst_i || !unit_en) begin
      transfer_in_progress_flag <= 1'b0;
    end else begin
      transfer_in_progress_flag <= (state == csa_pkg::ST_IDLE) ? (single_start || auto_start)
                                   : (state != csa_pkg::ST_STORE);
    end
  end

  // Shift register: loaded, then one bit in per rising clock edge
  always_ff @(posedge clk_i) begin
    if (rst_i || !unit_en) begin
      serial_shift_register <= 8'h00;
    end else if (state == csa_pkg::ST_IDLE && bus_wr && addr_is(wb_adr_i, csa_pkg::ADDR_SHIFT)) begin
      serial_shift_register <= wb_dat_i[7:0];
    end else if (state == csa_pkg::ST_IDLE && auto_start) begin
      serial_shift_register <= buf_ram[transfer_address_counter[csa_pkg::BUF_AW-1:0]];
    end else if (state == csa_pkg::ST_SHIFT && rise) begin
      serial_shift_register <= lsb_first ? {in_bit, serial_shift_register[7:1]}
                                         : {serial_shift_register[6:0], in_bit};
    end
  end

  // Outgoing bit changes on the falling clock edge
  always_ff @(posedge clk_i) begin
    if (rst_i || !unit_en) begin
      out_bit <= 1'b0;
    end else if (state == csa_pkg::ST_LOAD || (state == csa_pkg::ST_SHIFT && fall)) begin
      out_bit <= head_bit(serial_shift_register, lsb_first);
    end
  end

  // Data out pin: low while disabled or transmit off
  always_ff @(posedge clk_i) begin
    if (rst_i || !unit_en) begin
      serial_data_out_o <= 1'b0;
    end else begin
      serial_data_out_o <= tx_en && transfer_in_progress_flag && out_bit;
    end
  end

  // Clock pin: high at rest, toggled by the divider in master mode
  always_ff @(posedge clk_i) begin
    if (rst_i || !unit_en || !master || state != csa_pkg::ST_SHIFT) begin
      serial_clock_line_o <= 1'b1;
    end else if (rise || fall) begin
      serial_clock_line_o <= !serial_clock_line_o;
    end
  end

  // Clock pin driven only as master
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_clock_line_oe_o <= 1'b0;
    end else begin
      serial_clock_line_oe_o <= master;
    end
  end

  // ==========================================================================
  // Automatic transfer counter and trigger
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (rst_i || !unit_en) begin
      transfer_address_counter <= '0;
    end else if (state == csa_pkg::ST_STORE && auto_en) begin
      transfer_address_counter <= transfer_address_counter + 1'b1;
    end else if (bus_wr && addr_is(wb_adr_i, csa_pkg::ADDR_ADR_CNT)) begin
      transfer_address_counter <= wb_dat_i[csa_pkg::BUF_AW:0];
    end
  end

  // Trigger: set by software, cleared at end of a single sequence
  always_ff @(posedge clk_i) begin
    if (rst_i || !unit_en) begin
      serial_trigger <= 1'b0;
    end else if (state == csa_pkg::ST_STORE && auto_en && !repeat_en
                 && transfer_address_counter[csa_pkg::BUF_AW-1:0] == transfer_end_pointer) begin
      serial_trigger <= 1'b0;
    end else if (bus_wr && addr_is(wb_adr_i, csa_pkg::ADDR_TRIGGER)) begin
      serial_trigger <= wb_dat_i[csa_pkg::BIT_TRIG];
    end
  end

  // Buffer RAM: bus writes while enabled, received bytes in auto mode
  always_ff @(posedge clk_i) begin
    if (state == csa_pkg::ST_STORE && auto_en && rx_en) begin
      buf_ram[transfer_address_counter[csa_pkg::BUF_AW-1:0]] <= serial_shift_register;
    end else if (bus_wr && buf_hit && unit_en) begin
      buf_ram[buf_idx] <= wb_dat_i[7:0];
    end
  end

  // ==========================================================================
  // Receive FIFO for single byte mode
  // ==========================================================================
  assign fifo_push = (state == csa_pkg::ST_STORE) && !auto_en && rx_en;
  assign fifo_pop  = bus_rd && addr_is(wb_adr_i, csa_pkg::ADDR_RX_DATA);

  csa_fifo #(
    .WIDTH (csa_pkg::BYTE_BITS),
    .DEPTH (csa_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .clr_i       (!unit_en),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (serial_shift_register),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out_data)
  );

endmodule // csa_serial_ctrl

`default_nettype wire

// *** csa_pkg.sv ***
// Package holding constants and types of the serial auto transfer controller
`default_nettype none

package csa_pkg;

  // ==========================================================================
  // Register byte addresses
  // ==========================================================================
  localparam logic [15:0] ADDR_MODE    = 16'hFF90; // serial_mode_control
  localparam logic [15:0] ADDR_END_PTR = 16'hFF94; // transfer_end_pointer
  localparam logic [15:0] ADDR_ADR_CNT = 16'hFF98; // transfer_address_counter
  localparam logic [15:0] ADDR_TRIGGER = 16'hFF9C; // serial_trigger
  localparam logic [15:0] ADDR_STATUS  = 16'hFFA0; // serial_status_register
  localparam logic [15:0] ADDR_SHIFT   = 16'hFFA4; // serial_shift_register
  localparam logic [15:0] ADDR_RX_DATA = 16'hFFA8; // Receive FIFO head, read pops
  localparam logic [15:0] ADDR_BUF_LO  = 16'hFE00; // First buffer RAM word
  localparam logic [15:0] ADDR_BUF_HI  = 16'hFE7C; // Last buffer RAM word

  // ==========================================================================
  // Mode register fields and reset values
  // ==========================================================================
  localparam int BIT_UNIT_EN   = 7; // serial_unit_enable
  localparam int BIT_AUTO_EN   = 6; // auto_comm_enable
  localparam int BIT_REPEAT    = 5; // auto_repeat_select
  localparam int BIT_ROLE      = 4; // role_select, 1 = master
  localparam int BIT_TX_EN     = 3; // transmit_enable
  localparam int BIT_RX_EN     = 2; // receive_enable
  localparam int BIT_ORDER     = 1; // first_bit_order, 1 = LSB first
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [7:0] MODE_WR_MASK  = 8'hFE; // Bit 0 fixed at zero

  // Status, receive data and trigger register fields
  localparam int BIT_ST_BUSY   = 0; // transfer_in_progress_flag
  localparam int BIT_ST_RXVAL  = 1; // Receive FIFO holds data
  localparam int BIT_ST_RXFULL = 2; // Receive FIFO full
  localparam int BIT_ST_ADONE  = 3; // Auto sequence reached end address
  localparam int BIT_RX_VALID  = 8; // Valid flag in receive data word
  localparam int BIT_TRIG      = 0; // Trigger bit in serial_trigger

  // ==========================================================================
  // Sizes and timing
  // ==========================================================================
  localparam int BUF_DEPTH     = 32;
  localparam int BUF_AW        = 5;
  localparam int FIFO_DEPTH    = 8;
  localparam int BYTE_BITS     = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_HALF_NS   = 100; // Master serial clock half period
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Transfer engine states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_LOAD  = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_STORE = 4'b1000
  } csa_state_type;

endpackage : csa_pkg

`default_nettype wire

// *** csa_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module csa_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  input  wire logic [WIDTH-1:0] init_i,
  output var  logic [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge clk_i) begin
    stage1 <= pin_i;
    stage2 <= stage1;
    stage3 <= stage2;
  end

  // Level starts at the pin's idle level, so no false edge follows reset,
  // then follows once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          level_o[g] <= init_i[g];
        end else if (stage2[g] == stage3[g]) begin
          level_o[g] <= stage3[g];
        end
      end
    end
  endgenerate

endmodule // csa_sync

`default_nettype wire

// *** csa_fifo.sv ***
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module csa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             clr_i,
  input  wire logic             in_valid_i,
  output var  logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output var  logic             out_valid_o,
  input  wire logic             out_ready_i,
  output var  logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  // Storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // csa_fifo

`default_nettype wire

// *** csa_serial_ctrl_assertions.sv ***
// Port checker for the serial auto transfer controller
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Checker
module csa_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        serial_data_out_o,
  input wire logic        serial_clock_line_o,
  input wire logic        serial_clock_line_oe_o
);
  logic [7:0] mode;
  logic       req;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken at this edge
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Mirror of the mode byte as software wrote it
  always_ff @(posedge clk_i) begin
    if (rst_i) mode <= 8'h00;
    else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == csa_pkg::ADDR_MODE) mode <= wb_dat_i[7:0] & 8'hFE;
  end
  ack_follows_a: assert property (req |=> wb_ack_o) else $error("ack late");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  mode_read_a: assert property (req && !wb_we_i && wb_adr_i == csa_pkg::ADDR_MODE
    |=> wb_dat_o == {24'h0, mode}) else $error("mode read");
  off_idle_a: assert property (!mode[7] [*3] |-> !serial_data_out_o && serial_clock_line_o) else $error("idle");
  tx_off_low_a: assert property (!mode[3] [*3] |-> !serial_data_out_o) else $error("data out");
  master_oe_a: assert property ((mode[4] && mode[7]) [*3] |-> serial_clock_line_oe_o) else $error("oe low");
  slave_oe_a: assert property (!mode[4] [*3] |-> !serial_clock_line_oe_o) else $error("oe high");
  low_half_a: assert property ($fell(serial_clock_line_o) && serial_clock_line_oe_o
    |=> !serial_clock_line_o [*8]) else $error("low half");
  high_half_a: assert property ($rose(serial_clock_line_o) && serial_clock_line_oe_o
    |=> serial_clock_line_o [*8]) else $error("high half");
  master_cov: cover property (mode[4] && $fell(serial_clock_line_o));
  slave_cov: cover property (!mode[4] && mode[3] && serial_data_out_o);
  read_cov: cover property (req && !wb_we_i && wb_adr_i == csa_pkg::ADDR_MODE);
endmodule // csa_chk
bind csa_serial_ctrl csa_chk u_chk (.*);
`default_nettype wire

// *** csa_peer_model.sv ***
// Far-side serial peer model
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Peer
module csa_peer (
  input  wire logic       sck_i,
  input  wire logic       sdo_i,
  input  wire logic       go_i,
  input  wire logic       gen_i,
  input  wire logic [7:0] tx_i,
  output var  logic       pclk_o,
  output var  logic       sdi_o,
  output var  logic [7:0] rx_o
);
  logic [2:0] n = 3'h0;
  initial pclk_o = 1'b1;
  initial sdi_o = 1'b0;
  // New frame; as clock master make 8 periods of 160 ns, high between frames
  always @(posedge go_i) begin
    n = 3'h0;
    if (gen_i) repeat (8) begin
      #80 pclk_o = 1'b0;
      #80 pclk_o = 1'b1;
    end
  end
  // Next bit after the falling edge
  always @(negedge sck_i) begin
    sdi_o = tx_i[3'h7 - n];
    n = n + 3'h1;
  end
  // Sample on the rising edge; after the last bit the line no longer holds
  always @(posedge sck_i) begin
    rx_o = {rx_o[6:0], sdo_i};
    if (n == 3'h0) #40 sdi_o = ~sdi_o;
  end
endmodule // csa_peer
`default_nettype wire

// *** test_csa_serial_ctrl.sv ***
// Self-checking bench of the serial auto transfer controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("MISMATCH %s %h %h", n, e, g); end end
// ==========================================
// Bench
module test_csa_serial_ctrl;
  logic        clk, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, gen = 1'b0;
  logic        ack, sdo, sco, oe, pclk, sdi;
  logic [3:0]  sel = 4'h0;
  logic [15:0] adr = 16'h0000;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [7:0]  txb = 8'hA5, rx;
  int          fails = 0, checks_done = 0;
  wire logic   sck = oe ? sco : pclk;
  localparam logic [31:0] ROWS [4] = '{{csa_pkg::ADDR_MODE, 16'h0F0E}, {csa_pkg::ADDR_END_PTR, 16'h1F1F},
    {csa_pkg::ADDR_BUF_LO, 16'hAA00}, {16'h0100, 16'h5500}};
  csa_serial_ctrl dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .serial_data_in_i(sdi),
    .serial_data_out_o(sdo), .serial_clock_line_i(sck), .serial_clock_line_o(sco), .serial_clock_line_oe_o(oe));
  csa_peer u_peer (.sck_i(sck), .sdo_i(sdo), .go_i(go), .gen_i(gen), .tx_i(txb), .pclk_o(pclk), .sdi_o(sdi), .rx_o(rx));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // One classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input string n, input logic [15:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    `CHK(n, e, q)
  endtask
  task automatic poll(input logic [15:0] a);
    int i = 0;
    do begin
      wb(1'b0, a, 8'h00);
      i++;
    end while (q[0] !== 1'b0 && i < 400);
    if (q[0] !== 1'b0) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic frame();
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic tally_and_finish();
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd("mode", csa_pkg::ADDR_MODE, 32'h0);
    rd("stat", csa_pkg::ADDR_STATUS, 32'h0);
    foreach (ROWS[r]) begin
      wb(1'b1, ROWS[r][31:16], ROWS[r][15:8]);
      rd("row", ROWS[r][31:16], {24'h0, ROWS[r][7:0]});
    end
    wb(1'b1, csa_pkg::ADDR_MODE, 8'h9C);
    frame();
    wb(1'b1, csa_pkg::ADDR_SHIFT, 8'h3C);
    rd("busy", csa_pkg::ADDR_STATUS, 32'h1);
    poll(csa_pkg::ADDR_STATUS);
    `CHK("msb", 8'h3C, rx)
    rd("fifo", csa_pkg::ADDR_RX_DATA, 32'h1A5);
    gen <= 1'b1;
    wb(1'b1, csa_pkg::ADDR_MODE, 8'h8A);
    wb(1'b1, csa_pkg::ADDR_SHIFT, 8'h1C);
    frame();
    poll(csa_pkg::ADDR_STATUS);
    `CHK("lsb", 8'h38, rx)
    rd("norx", csa_pkg::ADDR_STATUS, 32'h0);
    gen <= 1'b0;
    wb(1'b1, csa_pkg::ADDR_MODE, 8'hDC);
    wb(1'b1, 16'hFE04, 8'h22);
    wb(1'b1, csa_pkg::ADDR_END_PTR, 8'h01);
    frame();
    wb(1'b1, csa_pkg::ADDR_TRIGGER, 8'h01);
    poll(csa_pkg::ADDR_TRIGGER);
    poll(csa_pkg::ADDR_STATUS);
    `CHK("auto", 8'h22, rx)
    rd("cnt", csa_pkg::ADDR_ADR_CNT, 32'h2);
    rd("back", csa_pkg::ADDR_BUF_LO, 32'hA5);
    wb(1'b1, csa_pkg::ADDR_MODE, 8'h5C);
    rd("c0", csa_pkg::ADDR_ADR_CNT, 32'h0);
    rd("s0", csa_pkg::ADDR_SHIFT, 32'h0);
    rd("b0", csa_pkg::ADDR_BUF_LO, 32'h0);
    wb(1'b1, csa_pkg::ADDR_MODE, 8'hF4);
    wb(1'b1, csa_pkg::ADDR_END_PTR, 8'h00);
    wb(1'b1, csa_pkg::ADDR_TRIGGER, 8'h01);
    poll(csa_pkg::ADDR_STATUS);
    rd("rep", csa_pkg::ADDR_STATUS, 32'h8);
    wb(1'b1, csa_pkg::ADDR_ADR_CNT, 8'h00);
    poll(csa_pkg::ADDR_STATUS);
    `CHK("txoff", 8'h00, rx)
    rd("rtrig", csa_pkg::ADDR_TRIGGER, 32'h1);
    tally_and_finish();
  end
endmodule // test_csa_serial_ctrl
`default_nettype wire
